// *** dss_pkg.sv ***
// Purpose: shared constants and types for the spread/scramble/encode block
// Assumes: APB data 32 bits, register byte address = 4 * register index
// Notes: code length field values 0..3 stand for 11, 13, 15, 16 chips
package dss_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TX_LEN = 8'h04;
  localparam logic [7:0] IDX_TX_CODE_HI = 8'h0d;
  localparam logic [7:0] IDX_TX_CODE_LO = 8'h0e;
  localparam logic [7:0] IDX_SCR_SEED = 8'h0f;
  localparam logic [7:0] IDX_SCR_TAP = 8'h10;
  localparam logic [7:0] IDX_RX_CODE_1 = 8'h14;
  localparam logic [7:0] IDX_RX_CODE_2 = 8'h15;
  localparam logic [7:0] IDX_CTRL = 8'h3c;
  localparam logic [7:0] IDX_STATUS = 8'h3d;

  // field positions
  localparam int LEN_LSB = 5;
  localparam int CTRL_SCR_EN = 0;
  localparam int CTRL_DQPSK = 1;

  // values after reset
  localparam logic [7:0] RST_LEN = 8'h00;
  localparam logic [7:0] RST_CODE = 8'h00;
  localparam logic [6:0] RST_SEED = 7'h00;
  localparam logic [6:0] RST_TAP = 7'h48;
  localparam logic [1:0] RST_CTRL = 2'h1;

  // chips per symbol minus one (index of the first chip sent) for each length code
  localparam logic [3:0] CHIPS_11 = 4'ha;
  localparam logic [3:0] CHIPS_13 = 4'hc;
  localparam logic [3:0] CHIPS_15 = 4'he;
  localparam logic [3:0] CHIPS_16 = 4'hf;

  // differential phase steps in quarter turns, counterclockwise positive
  localparam logic [1:0] STEP_00 = 2'h0;
  localparam logic [1:0] STEP_01 = 2'h1;
  localparam logic [1:0] STEP_11 = 2'h2;
  localparam logic [1:0] STEP_10 = 2'h3;

  typedef enum logic {ST_IDLE, ST_SPREAD} dss_state_e;

  // one serial transmit bit and its frame position
  typedef struct packed {
    logic data;
    logic payload;
  } dss_txbit_s;

  // one chip leaving the modulator
  typedef struct packed {
    logic valid;
    logic i;
    logic q;
  } dss_chip_s;

endpackage

// *** dss_scrambler.sv ***
// Purpose: self-synchronizing 7-bit scrambler / descrambler
// Assumes: step is a one-cycle strobe per data bit
// Notes: same polynomial division in both directions
`timescale 1ns/10ps
`default_nettype none
module dss_scrambler #(
  parameter bit DESCRAMBLE = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration
  input wire logic load,
  input wire logic [6:0] seed,
  input wire logic [6:0] taps,
  // data
  input wire logic step,
  input wire logic din,
  output logic dout
);

  logic [6:0] sr_q;
  logic [6:0] sr_d;
  wire fb = ^(sr_q & taps);
  // the quotient bit is the line bit in both directions
  wire line_bit = DESCRAMBLE ? din : (din ^ fb);

  assign dout = din ^ fb;
  // seed load wins over a step so a preset is never lost
  assign sr_d = load ? seed : (step ? {sr_q[5:0], line_bit} : sr_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sr_q <= 7'h00;
    else
      sr_q <= sr_d;
  end

  shift_newest_a: assert property (@(posedge pclk) disable iff (!presetn)
    (step && !load) |=> sr_q[0] == $past(line_bit))
    else $error("scrambler shifted a wrong quotient bit");

endmodule // dss_scrambler
`default_nettype wire

// *** dss_spread_encode.sv ***
// Purpose: scramble, differential encode and PN spread the transmit stream
// Assumes: one chip per pclk cycle; host holds tx bit until tx_ready_q
// Notes: APB slave with one wait state; receive descrambler beside it
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dss_spread_encode (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial transmit bits from the host
  input wire logic tx_bit_valid,
  input wire dss_pkg::dss_txbit_s tx_bit,
  output logic tx_ready_q,
  // chip stream out
  output dss_pkg::dss_chip_s chip_q,
  // receive side
  input wire logic rx_line_valid,
  input wire logic rx_line_bit,
  output logic rx_data_valid_q,
  output logic rx_data_q,
  output logic [15:0] rx_despread_code_q
);

  ////////////////////////////////////////////////////////////////////////
  // apb register file

  logic [7:0] len_cfg_q, code_hi_q, code_lo_q, rx1_q, rx2_q;
  logic [6:0] seed_q, tap_q;
  logic [1:0] ctrl_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic seed_load_q;
  dss_pkg::dss_state_e state_q;
  logic [1:0] phase_q;

  // byte address must be word aligned; index is the word number
  wire [7:0] idx = paddr[9:2];
  wire aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  wire access = psel && penable && !pready_q;
  wire wr_done = psel && penable && pready_q && pwrite && !pslverr_q;
  wire hit_len = aligned && idx == dss_pkg::IDX_TX_LEN;
  wire hit_hi = aligned && idx == dss_pkg::IDX_TX_CODE_HI;
  wire hit_lo = aligned && idx == dss_pkg::IDX_TX_CODE_LO;
  wire hit_seed = aligned && idx == dss_pkg::IDX_SCR_SEED;
  wire hit_tap = aligned && idx == dss_pkg::IDX_SCR_TAP;
  wire hit_rx1 = aligned && idx == dss_pkg::IDX_RX_CODE_1;
  wire hit_rx2 = aligned && idx == dss_pkg::IDX_RX_CODE_2;
  wire hit_ctrl = aligned && idx == dss_pkg::IDX_CTRL;
  wire hit_stat = aligned && idx == dss_pkg::IDX_STATUS;
  wire hit_any = hit_len | hit_hi | hit_lo | hit_seed | hit_tap | hit_rx1 | hit_rx2 |
    hit_ctrl | hit_stat;
  wire [31:0] rd_mux =
    hit_len ? {24'h0, len_cfg_q} :
    hit_hi ? {24'h0, code_hi_q} :
    hit_lo ? {24'h0, code_lo_q} :
    hit_seed ? {25'h0, seed_q} :
    hit_tap ? {25'h0, tap_q} :
    hit_rx1 ? {24'h0, rx1_q} :
    hit_rx2 ? {24'h0, rx2_q} :
    hit_ctrl ? {30'h0, ctrl_q} :
    hit_stat ? {29'h0, phase_q, state_q == dss_pkg::ST_SPREAD} : 32'h0;

  // answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= access;
      pslverr_q <= access && !hit_any;
      prdata_q <= (access && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // write side; status is read only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      len_cfg_q <= dss_pkg::RST_LEN;
      code_hi_q <= dss_pkg::RST_CODE;
      code_lo_q <= dss_pkg::RST_CODE;
      rx1_q <= dss_pkg::RST_CODE;
      rx2_q <= dss_pkg::RST_CODE;
      seed_q <= dss_pkg::RST_SEED;
      tap_q <= dss_pkg::RST_TAP;
      ctrl_q <= dss_pkg::RST_CTRL;
      seed_load_q <= 1'b0;
    end
    else
    begin
      if (wr_done && hit_len) len_cfg_q <= pwdata[7:0];
      if (wr_done && hit_hi) code_hi_q <= pwdata[7:0];
      if (wr_done && hit_lo) code_lo_q <= pwdata[7:0];
      if (wr_done && hit_rx1) rx1_q <= pwdata[7:0];
      if (wr_done && hit_rx2) rx2_q <= pwdata[7:0];
      if (wr_done && hit_seed) seed_q <= pwdata[6:0];
      if (wr_done && hit_tap) tap_q <= pwdata[6:0];
      if (wr_done && hit_ctrl) ctrl_q <= pwdata[1:0];
      seed_load_q <= wr_done && hit_seed;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////
  // bit intake, scrambling and dibit forming

  logic nxt_full_q, nxt_half_q, nxt_b0_q;
  logic [1:0] nxt_dibit_q;
  logic [3:0] chip_idx_q, len_q;
  logic scr_out, rx_out;

  wire scr_en = ctrl_q[dss_pkg::CTRL_SCR_EN];
  // header and preamble never use the second bit
  wire two_bits = ctrl_q[dss_pkg::CTRL_DQPSK] && tx_bit.payload;
  wire take = tx_bit_valid && tx_ready_q && !nxt_full_q;
  wire line_bit = scr_en ? scr_out : tx_bit.data;
  wire completes = take && (!two_bits || nxt_half_q);
  wire sym_start = nxt_full_q && (state_q == dss_pkg::ST_IDLE || chip_idx_q == 4'h0);
  wire spread_end = state_q == dss_pkg::ST_SPREAD && chip_idx_q == 4'h0 && !nxt_full_q;
  wire nxt_full_d = sym_start ? 1'b0 : (completes ? 1'b1 : nxt_full_q);

  dss_scrambler #(
    .DESCRAMBLE(1'b0)
  ) u_tx_scr (
    .pclk(pclk),
    .presetn(presetn),
    .load(seed_load_q),
    .seed(seed_q),
    .taps(tap_q),
    .step(take && scr_en),
    .din(tx_bit.data),
    .dout(scr_out)
  );

  // receive path shares the algorithm, seed unused there
  dss_scrambler #(
    .DESCRAMBLE(1'b1)
  ) u_rx_scr (
    .pclk(pclk),
    .presetn(presetn),
    .load(1'b0),
    .seed(dss_pkg::RST_SEED),
    .taps(tap_q),
    .step(rx_line_valid && scr_en),
    .din(rx_line_bit),
    .dout(rx_out)
  );

  // one symbol of look-ahead keeps chips back to back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nxt_full_q <= 1'b0;
      nxt_half_q <= 1'b0;
      nxt_b0_q <= 1'b0;
      nxt_dibit_q <= 2'h0;
      tx_ready_q <= 1'b0;
    end
    else
    begin
      nxt_full_q <= nxt_full_d;
      tx_ready_q <= !nxt_full_d;
      if (take && two_bits && !nxt_half_q)
      begin
        nxt_half_q <= 1'b1;
        nxt_b0_q <= line_bit;
      end
      else if (completes)
      begin
        nxt_half_q <= 1'b0;
        // dbpsk repeats the bit: only 00 or 11
        nxt_dibit_q <= two_bits ? {nxt_b0_q, line_bit} : {line_bit, line_bit};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // differential phase and pn spreading

  wire [3:0] len_sel =
    (len_cfg_q[dss_pkg::LEN_LSB +: 2] == 2'h0) ? dss_pkg::CHIPS_11 :
    (len_cfg_q[dss_pkg::LEN_LSB +: 2] == 2'h1) ? dss_pkg::CHIPS_13 :
    (len_cfg_q[dss_pkg::LEN_LSB +: 2] == 2'h2) ? dss_pkg::CHIPS_15 : dss_pkg::CHIPS_16;
  wire [1:0] step =
    (nxt_dibit_q == 2'h0) ? dss_pkg::STEP_00 :
    (nxt_dibit_q == 2'h1) ? dss_pkg::STEP_01 :
    (nxt_dibit_q == 2'h3) ? dss_pkg::STEP_11 : dss_pkg::STEP_10;
  wire [15:0] tx_code = {code_hi_q, code_lo_q};
  wire code_bit = tx_code[chip_idx_q];
  // phase index k stands for 45 + 90k degrees
  wire i_neg = phase_q[1] ^ phase_q[0];
  wire q_neg = phase_q[1];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= dss_pkg::ST_IDLE;
      phase_q <= 2'h0;
      len_q <= dss_pkg::CHIPS_11;
      chip_idx_q <= 4'h0;
    end
    else if (sym_start)
    begin
      state_q <= dss_pkg::ST_SPREAD;
      phase_q <= phase_q + step;
      len_q <= len_sel;
      chip_idx_q <= len_sel;
    end
    else if (spread_end)
      state_q <= dss_pkg::ST_IDLE;
    else if (state_q == dss_pkg::ST_SPREAD)
      chip_idx_q <= chip_idx_q - 4'h1;
  end

  // chip sign: code bit flips the symbol phasor
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chip_q <= '0;
    else
    begin
      chip_q.valid <= state_q == dss_pkg::ST_SPREAD;
      chip_q.i <= code_bit ^ i_neg;
      chip_q.q <= code_bit ^ q_neg;
    end
  end

  // receive descrambler output and code for the correlator
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_data_valid_q <= 1'b0;
      rx_data_q <= 1'b0;
      rx_despread_code_q <= 16'h0;
    end
    else
    begin
      rx_data_valid_q <= rx_line_valid;
      rx_data_q <= scr_en ? rx_out : rx_line_bit;
      rx_despread_code_q <= {rx1_q, rx2_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence sym_begin_s;
    sym_start;
  endsequence

  len_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == dss_pkg::ST_SPREAD && !sym_start) |=> $stable(len_q))
    else $error("code length changed inside a symbol");
  msb_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    sym_begin_s |=> chip_idx_q == len_q ##1 chip_q.valid)
    else $error("chip sequence did not start at top used bit");
  len_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sym_start && len_cfg_q[6:5] == 2'h3) |=> len_q == 4'hf)
    else $error("length 16 code mapped wrong");
  bpsk_dibit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (completes && !two_bits) |=> nxt_dibit_q[1] == nxt_dibit_q[0])
    else $error("dbpsk produced a 01 or 10 dibit");
  phase_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sym_start && nxt_dibit_q == 2'h1) |=> phase_q == $past(phase_q) + 2'h1)
    else $error("dibit 01 did not rotate by +90");
  scr_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (completes && !two_bits && !scr_en) |=> nxt_dibit_q[0] == $past(tx_bit.data))
    else $error("disabled scrambler altered data");
  chip_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sym_start && len_sel == 4'ha) |=> ##1 chip_q.valid [*8])
    else $error("chips not emitted every cycle");
  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait cycle");

endmodule // dss_spread_encode
`default_nettype wire

// *** dss_host_model.sv ***
// Purpose: host model feeding serial transmit bits
// Assumes: a bit is taken on valid and ready at a rising edge
// Notes: idle data line toggles, so a stale bit never looks valid
`timescale 1ns/10ps
`default_nettype none
module dss_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // transmit port
  input wire logic tx_ready_q,
  output logic tx_bit_valid,
  output dss_pkg::dss_txbit_s tx_bit
);
  dss_pkg::dss_txbit_s q[$];
  logic slow = 1'b0;
  logic taken;
  assign taken = tx_bit_valid && tx_ready_q;
  // queue a bit; the bench programs codes and length first
  task automatic push(input logic d, input logic p);
    q.push_back('{data: d, payload: p});
  endtask
  ////////////////////////////////////////
  // hold each bit until taken; slow mode idles a cycle between bits
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_bit_valid <= 1'b0;
      tx_bit <= '0;
    end
    else if (!tx_bit_valid || taken)
    begin
      if (taken)
        void'(q.pop_front());
      if (q.size() > 0 && !(slow && taken))
      begin
        tx_bit_valid <= 1'b1;
        tx_bit <= q[0];
      end
      else
      begin
        tx_bit_valid <= 1'b0;
        tx_bit.data <= ~tx_bit.data;
      end
    end
  end
endmodule // dss_host_model
`default_nettype wire

// *** dss_spread_encode_tb.sv ***
// Purpose: self-checking bench for the spread/scramble/encode block
// Assumes: phase index starts at zero after reset
// Notes: taps and seed chosen bit-symmetric, so shift direction cannot matter
`timescale 1ns/10ps
`default_nettype none
module dss_spread_encode_tb;
  logic pclk, presetn, psel, penable, pwrite, tx_bit_valid, tx_ready_q, pready, pslverr;
  logic rx_line_valid, rx_line_bit, rx_data_valid_q, rx_data_q, scr_on, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] rx_despread_code_q, code;
  logic [1:0] got[$], exp[$], ph;
  logic [6:0] st, tp;
  int mismatches, checks, cyc, len;
  dss_pkg::dss_txbit_s tx_bit;
  dss_pkg::dss_chip_s chip_q;
  dss_spread_encode u_dss_spread_encode (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit),
    .tx_ready_q(tx_ready_q), .chip_q(chip_q), .rx_line_valid(rx_line_valid),
    .rx_line_bit(rx_line_bit), .rx_data_valid_q(rx_data_valid_q), .rx_data_q(rx_data_q),
    .rx_despread_code_q(rx_despread_code_q));
  dss_host_model u_dss_host_model (.pclk(pclk), .presetn(presetn), .tx_ready_q(tx_ready_q),
    .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // apb transfer; pready, prdata and pslverr are taken as sampled at a rising edge,
  // and the request is released only at the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] e, input string nm);
    apb(1'b0, idx, 32'h0);
    chk(nm, e, rd);
  endtask
  // reference scrambler, bypassed when off
  function automatic logic scr(input logic d);
    logic o;
    o = scr_on ? d ^ (^(st & tp)) : d;
    if (scr_on)
      st = {st[5:0], o};
    return o;
  endfunction
  // expected chips of one symbol after its phase step
  task automatic sym(input logic [1:0] s);
    ph = ph + s;
    for (int c = len - 1; c >= 0; c--)
      exp.push_back({(ph == 2'h1 || ph == 2'h2) ^ code[c], ph[1] ^ code[c]});
  endtask
  task automatic tx1(input logic d);
    u_dss_host_model.push(d, 1'b0);
    sym(scr(d) ? 2'h2 : 2'h0);
  endtask
  task automatic tx2(input logic a, input logic b);
    logic [1:0] p;
    u_dss_host_model.push(a, 1'b1);
    u_dss_host_model.push(b, 1'b1);
    p[1] = scr(a);
    p[0] = scr(b);
    sym(p == 2'b01 ? 2'h1 : p == 2'b11 ? 2'h2 : p == 2'b10 ? 2'h3 : 2'h0);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (got.size() < exp.size() && n < 3000)
    begin
      @(negedge pclk);
      n++;
    end
    repeat (4) @(negedge pclk);
    chk("chip count", exp.size(), got.size());
    foreach (exp[j])
      chk("chip", exp[j], j < got.size() ? got[j] : 2'bxx);
    got.delete();
    exp.delete();
  endtask
  task automatic rxb(input logic b, input logic cmp);
    logic o;
    o = scr_on ? b ^ (^(st & tp)) : b;
    st = {st[5:0], b};
    @(posedge pclk);
    rx_line_valid <= 1'b1;
    rx_line_bit <= b;
    @(posedge pclk);
    rx_line_valid <= 1'b0;
    rx_line_bit <= ~b;
    @(negedge pclk);
    chk("rx valid", 1'b1, rx_data_valid_q);
    if (cmp)
      chk("rx data", o, rx_data_q);
  endtask
  ////////////////////////////////////////
  // chip monitor and clock
  always @(negedge pclk)
    if (chip_q.valid === 1'b1)
      got.push_back({chip_q.i, chip_q.q});
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  initial
  begin
    {psel, penable, pwrite, rx_line_valid, rx_line_bit, scr_on, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    {ph, st, tp, code} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(dss_pkg::IDX_TX_LEN, dss_pkg::RST_LEN, "len");
    rdchk(dss_pkg::IDX_TX_CODE_HI, dss_pkg::RST_CODE, "code hi");
    rdchk(dss_pkg::IDX_SCR_SEED, dss_pkg::RST_SEED, "seed");
    rdchk(dss_pkg::IDX_SCR_TAP, dss_pkg::RST_TAP, "taps");
    rdchk(dss_pkg::IDX_CTRL, dss_pkg::RST_CTRL, "ctrl");
    // unmapped word: error, write dropped, reads zero
    apb(1'b1, 8'h01, 32'hff);
    rdchk(8'h01, 32'h0, "unmapped");
    chk("slverr", 1'b1, err);
    apb(1'b1, dss_pkg::IDX_TX_CODE_HI, 32'h05);
    apb(1'b1, dss_pkg::IDX_TX_CODE_LO, 32'ha3);
    apb(1'b1, dss_pkg::IDX_RX_CODE_1, 32'h12);
    apb(1'b1, dss_pkg::IDX_RX_CODE_2, 32'h34);
    rdchk(dss_pkg::IDX_TX_CODE_LO, 32'ha3, "code lo");
    chk("rx code", 16'h1234, rx_despread_code_q);
    code = 16'h05a3;
    apb(1'b1, dss_pkg::IDX_CTRL, 32'h0);
    // every length code, unscrambled DBPSK
    for (int lc = 0; lc < 4; lc++)
    begin
      apb(1'b1, dss_pkg::IDX_TX_LEN, lc << 5);
      len = (lc == 3) ? 16 : 11 + 2 * lc;
      tx1(1'b1);
      tx1(1'b0);
      tx1(1'b1);
      drain();
    end
    // DBPSK header bit, then DQPSK payload with a stalling host
    apb(1'b1, dss_pkg::IDX_CTRL, 32'h2);
    u_dss_host_model.slow = 1'b1;
    tx1(1'b1);
    tx2(1'b0, 1'b1);
    tx2(1'b1, 1'b0);
    tx2(1'b1, 1'b1);
    tx2(1'b0, 1'b0);
    drain();
    // idle status: not busy, phase index as the reference tracked it
    rdchk(dss_pkg::IDX_STATUS, {29'h0, ph, 1'b0}, "status");
    u_dss_host_model.slow = 1'b0;
    // scrambled DBPSK from a preset seed, then bypass
    apb(1'b1, dss_pkg::IDX_SCR_TAP, 32'h41);
    apb(1'b1, dss_pkg::IDX_SCR_SEED, 32'h63);
    apb(1'b1, dss_pkg::IDX_CTRL, 32'h1);
    {tp, st, scr_on} = {7'h41, 7'h63, 1'b1};
    for (int b = 0; b < 10; b++)
      tx1(b % 3 == 0);
    drain();
    apb(1'b1, dss_pkg::IDX_CTRL, 32'h0);
    scr_on = 1'b0;
    tx1(1'b1);
    tx1(1'b1);
    drain();
    rxb(1'b1, 1'b1);
    apb(1'b1, dss_pkg::IDX_CTRL, 32'h1);
    scr_on = 1'b1;
    // descrambler locks once seven line bits have passed
    for (int b = 0; b < 14; b++)
      rxb(b[0] ^ b[2], b >= 7);
    wrap_up();
  end
endmodule // dss_spread_encode_tb
`default_nettype wire
